// [rtl/umspi_top.sv]
// master spi serial port: registers, transmit buffer, shifter and clock generator
`timescale 1ns/1ps
`include "umspi_regs.svh"
module umspi_top (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic       global_irq_en_i,
  input  wire logic       rxc_irq_ack_i,
  input  wire logic       txc_irq_ack_i,
  output logic            rxc_irq_o,
  output logic            txc_irq_o,
  output logic            udre_irq_o,
  input  wire logic       serial_in_pin_i,
  output logic            serial_in_claim_o,
  output logic            serial_out_pin_o,
  output logic            serial_out_claim_o,
  output logic            serial_clock_pin_o
);
  ////////////////////////////////////////////////////////////////
  umspi_pkg::umspi_state_e state_reg;
  logic [7:0]              ctrl_reg;
  logic [7:0]              mode_reg;
  logic [11:0]             baud_divider_reg;
  logic [11:0]             div_cnt_reg;
  umspi_pkg::umspi_byte_t  txbuf_reg;
  logic                    txbuf_full_reg;
  umspi_pkg::umspi_byte_t  tx_shift_reg;
  umspi_pkg::umspi_byte_t  rx_shift_reg;
  logic [3:0]              bit_cnt_reg;
  logic                    txc_reg;
  logic                    tx_active_reg;
  logic                    sclk_reg;
  logic                    sin_sync;
  logic                    rx_nonempty;
  umspi_pkg::umspi_byte_t  rx_head;
  logic                    rx_push;
  logic                    rx_pop;
  logic                    tick;
  logic                    frame_done;
  logic                    load_shift;
  logic                    data_wr;
  logic                    spi_mode;
  logic                    order_lsb;
  logic                    cpha;
  logic                    cpol;
  umspi_pkg::umspi_byte_t  rx_next;
  logic [7:0]              status_rd;

  function automatic logic out_bit(input umspi_pkg::umspi_byte_t v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  function automatic umspi_pkg::umspi_byte_t shift_out(input umspi_pkg::umspi_byte_t v, input logic lsb);
    shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  assign spi_mode  = (mode_reg[7:6] == `UMSPI_MODE_SPI);
  assign order_lsb = mode_reg[`UMSPI_MD_ORDER];
  assign cpha      = mode_reg[`UMSPI_MD_PHASE];
  assign cpol      = mode_reg[`UMSPI_MD_POL];
  assign data_wr   = wr_i && (addr_i == `UMSPI_ADDR_DATA);

  ////////////////////////////////////////////////////////////////
  // no select input and no collision flag: master only
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= `UMSPI_CTRL_RESET;
    end else if (wr_i && addr_i == `UMSPI_ADDR_CTRL) begin
      ctrl_reg <= (wdata_i & 8'hF8) | (`UMSPI_CTRL_RESET & 8'h07);
    end
  end

  // order, phase and polarity land in the same write as the mode field
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mode_reg <= `UMSPI_MODE_RESET;
    end else if (wr_i && addr_i == `UMSPI_ADDR_MODE) begin
      mode_reg <= {wdata_i[7:6], 3'h0, wdata_i[2:0]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      baud_divider_reg <= 12'h000;
    end else if (wr_i && addr_i == `UMSPI_ADDR_BAUD_LO) begin
      baud_divider_reg[7:0] <= wdata_i;
    end else if (wr_i && addr_i == `UMSPI_ADDR_BAUD_HI) begin
      baud_divider_reg[11:8] <= wdata_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmitter stays active until shifter and buffer drain
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tx_active_reg <= 1'b0;
    end else if (ctrl_reg[`UMSPI_CT_TXEN] && spi_mode) begin
      tx_active_reg <= 1'b1;
    end else if (!txbuf_full_reg && state_reg == umspi_pkg::UMSPI_IDLE) begin
      tx_active_reg <= 1'b0;
    end
  end

  assign serial_out_claim_o = tx_active_reg;
  assign serial_in_claim_o  = ctrl_reg[`UMSPI_CT_RXEN];

  // writes while the buffer is full are ignored unless the buffer loads the shifter in that same cycle
  assign load_shift = txbuf_full_reg && state_reg == umspi_pkg::UMSPI_IDLE && tx_active_reg;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      txbuf_reg      <= 8'h00;
      txbuf_full_reg <= 1'b0;
    end else if (data_wr && (!txbuf_full_reg || load_shift)) begin
      txbuf_reg      <= wdata_i;
      txbuf_full_reg <= 1'b1;
    end else if (load_shift) begin
      txbuf_full_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // half-period tick: divider value plus one system clocks
  assign tick = (state_reg != umspi_pkg::UMSPI_IDLE) && (div_cnt_reg == baud_divider_reg);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || state_reg == umspi_pkg::UMSPI_IDLE || tick) begin
      div_cnt_reg <= 12'h000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 12'h001;
    end
  end

  assign frame_done = tick && state_reg == umspi_pkg::UMSPI_TRAIL && bit_cnt_reg == `UMSPI_FRAME_BITS - 4'h1;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_reg <= umspi_pkg::UMSPI_IDLE;
    end else begin
      case (state_reg)
        umspi_pkg::UMSPI_IDLE: begin
          if (load_shift) begin
            state_reg <= umspi_pkg::UMSPI_LEAD;
          end
        end
        umspi_pkg::UMSPI_LEAD: begin
          if (tick) begin
            state_reg <= umspi_pkg::UMSPI_TRAIL;
          end
        end
        umspi_pkg::UMSPI_TRAIL: begin
          if (frame_done) begin
            state_reg <= umspi_pkg::UMSPI_IDLE;
          end else if (tick) begin
            state_reg <= umspi_pkg::UMSPI_LEAD;
          end
        end
        default: begin
          state_reg <= umspi_pkg::UMSPI_IDLE;
        end
      endcase
    end
  end

  // leading edge at end of first half, trailing edge ends the bit
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sclk_reg <= 1'b0;
    end else if (state_reg == umspi_pkg::UMSPI_IDLE) begin
      sclk_reg <= cpol;
    end else if (tick) begin
      sclk_reg <= ~sclk_reg;
    end
  end
  assign serial_clock_pin_o = sclk_reg;

  assign rx_next = order_lsb ? {sin_sync, rx_shift_reg[7:1]} : {rx_shift_reg[6:0], sin_sync};

  // phase zero: sample on leading, shift on trailing; phase one reversed
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tx_shift_reg     <= 8'h00;
      rx_shift_reg     <= 8'h00;
      bit_cnt_reg      <= 4'h0;
      serial_out_pin_o <= 1'b1;
    end else if (load_shift) begin
      tx_shift_reg     <= cpha ? txbuf_reg : shift_out(txbuf_reg, order_lsb);
      serial_out_pin_o <= cpha ? 1'b1 : out_bit(txbuf_reg, order_lsb);
      bit_cnt_reg      <= 4'h0;
    end else if (tick) begin
      if ((state_reg == umspi_pkg::UMSPI_LEAD) != cpha) begin
        rx_shift_reg <= rx_next;
      end else if (!(frame_done && !cpha)) begin
        serial_out_pin_o <= out_bit(tx_shift_reg, order_lsb);
        tx_shift_reg     <= shift_out(tx_shift_reg, order_lsb);
      end
      if (state_reg == umspi_pkg::UMSPI_TRAIL) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else if (state_reg == umspi_pkg::UMSPI_IDLE) begin
      serial_out_pin_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // last sample lands with frame_done when phase is one
  assign rx_push = frame_done && ctrl_reg[`UMSPI_CT_RXEN];
  assign rx_pop  = rd_i && addr_i == `UMSPI_ADDR_DATA;

  umspi_sync u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (serial_in_pin_i),
    .q_o    (sin_sync)
  );

  umspi_rxbuf u_rxbuf (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .flush_i     (!ctrl_reg[`UMSPI_CT_RXEN]),
    .push_i      (rx_push),
    .push_data_i (cpha ? rx_next : rx_shift_reg),
    .pop_i       (rx_pop),
    .head_o      (rx_head),
    .nonempty_o  (rx_nonempty)
  );

  // set wins over software or service clear
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      txc_reg <= 1'b0;
    end else if (frame_done && !txbuf_full_reg) begin
      txc_reg <= 1'b1;
    end else if (txc_irq_ack_i || (wr_i && addr_i == `UMSPI_ADDR_STATUS && wdata_i[`UMSPI_ST_TXC])) begin
      txc_reg <= 1'b0;
    end
  end

  // reserved and error bits 4:0 read zero
  assign status_rd = {rx_nonempty, txc_reg, !txbuf_full_reg, 5'h00};

  assign rxc_irq_o  = ctrl_reg[`UMSPI_CT_RXCIE] && global_irq_en_i && rx_nonempty;
  assign txc_irq_o  = ctrl_reg[`UMSPI_CT_TXCIE] && global_irq_en_i && txc_reg;
  assign udre_irq_o = ctrl_reg[`UMSPI_CT_BUFFER_EMPTY_IRQ_ENABLE] && global_irq_en_i && !txbuf_full_reg;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `UMSPI_ADDR_DATA:    rdata_o <= rx_nonempty ? rx_head : 8'h00;
        `UMSPI_ADDR_STATUS:  rdata_o <= status_rd;
        `UMSPI_ADDR_CTRL:    rdata_o <= ctrl_reg;
        `UMSPI_ADDR_MODE:    rdata_o <= mode_reg;
        `UMSPI_ADDR_BAUD_LO: rdata_o <= baud_divider_reg[7:0];
        `UMSPI_ADDR_BAUD_HI: rdata_o <= {4'h0, baud_divider_reg[11:8]};
        default:             rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// [rtl/umspi_regs.svh]
// register offsets, field positions and reset values of the master spi serial port
`ifndef UMSPI_REGS_SVH
`define UMSPI_REGS_SVH
`define UMSPI_ADDR_DATA     3'h0
`define UMSPI_ADDR_STATUS   3'h1
`define UMSPI_ADDR_CTRL     3'h2
`define UMSPI_ADDR_MODE     3'h3
`define UMSPI_ADDR_BAUD_LO  3'h4
`define UMSPI_ADDR_BAUD_HI  3'h5
`define UMSPI_ST_RXC        7
`define UMSPI_ST_TXC        6
`define UMSPI_ST_UDRE       5
`define UMSPI_CT_RXCIE      7
`define UMSPI_CT_TXCIE      6
`define UMSPI_CT_BUFFER_EMPTY_IRQ_ENABLE      5
`define UMSPI_CT_RXEN       4
`define UMSPI_CT_TXEN       3
`define UMSPI_CTRL_RESET    8'h06
`define UMSPI_MODE_RESET    8'h06
`define UMSPI_MODE_SPI      2'h3
`define UMSPI_MD_ORDER      2
`define UMSPI_MD_PHASE      1
`define UMSPI_MD_POL        0
`define UMSPI_FRAME_BITS    4'h8
`endif

// [rtl/umspi_pkg.sv]
// types shared by the master spi serial port
package umspi_pkg;
  typedef enum logic [1:0] {
    UMSPI_IDLE  = 2'h0,
    UMSPI_LEAD  = 2'h1,
    UMSPI_TRAIL = 2'h3
  } umspi_state_e;
  typedef logic [7:0] umspi_byte_t;
endpackage

// [rtl/umspi_sync.sv]
// two flip-flop synchroniser for the serial input pin
`timescale 1ns/1ps
module umspi_sync (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// [rtl/umspi_rxbuf.sv]
// two-level receive buffer: one waiting byte and one output byte
`timescale 1ns/1ps
module umspi_rxbuf (
  input  wire logic                 mclk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 flush_i,
  input  wire logic                 push_i,
  input  wire umspi_pkg::umspi_byte_t push_data_i,
  input  wire logic                 pop_i,
  output umspi_pkg::umspi_byte_t    head_o,
  output logic                      nonempty_o
);
  umspi_pkg::umspi_byte_t mem_reg [0:1];
  logic [1:0]             count_reg;
  logic                   rd_ptr_reg;
  logic                   do_push;
  logic                   do_pop;
  // overflow drops the new byte, keeps older ones
  assign do_push    = push_i && (count_reg != 2'h2 || do_pop);
  assign do_pop     = pop_i && (count_reg != 2'h0);
  assign nonempty_o = (count_reg != 2'h0);
  assign head_o     = mem_reg[rd_ptr_reg];
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || flush_i) begin
      count_reg  <= 2'h0;
      rd_ptr_reg <= 1'b0;
    end else begin
      if (do_push) begin
        mem_reg[rd_ptr_reg ^ count_reg[0] ^ (do_pop ? 1'b1 : 1'b0) ^ (do_pop ? 1'b1 : 1'b0)] <= push_data_i;
      end
      if (do_pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + (do_push ? 2'h1 : 2'h0) - (do_pop ? 2'h1 : 2'h0);
    end
  end
endmodule

// [test/umspi_top_chk.sv]
// port assertions of the master spi serial port
`timescale 1ns/1ps
`include "umspi_regs.svh"
module umspi_top_chk (
  input wire logic       mclk_i,
  input wire logic       rstn_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       global_irq_en_i,
  input wire logic       txc_irq_ack_i,
  input wire logic       rxc_irq_o,
  input wire logic       txc_irq_o,
  input wire logic       udre_irq_o,
  input wire logic       serial_in_claim_o,
  input wire logic       serial_out_pin_o,
  input wire logic       serial_out_claim_o,
  input wire logic       serial_clock_pin_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_rdata_slot_only: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_status_reserved_zero: assert property ($past(rd_i && addr_i == `UMSPI_ADDR_STATUS) |-> rdata_o[4:0] == 5'h00)
    else $error("status reserved bits not zero");
  a_irq_needs_global: assert property (rxc_irq_o || txc_irq_o || udre_irq_o |-> global_irq_en_i)
    else $error("interrupt without global enable");
  a_rx_claim_follows: assert property (wr_i && addr_i == `UMSPI_ADDR_CTRL |=> serial_in_claim_o == $past(wdata_i[4]))
    else $error("receive pin claim wrong");
  a_tx_claim_takes: assert property (wr_i && addr_i == `UMSPI_ADDR_CTRL && wdata_i[3] |-> ##[1:3] serial_out_claim_o)
    else $error("transmit pin not claimed");
  a_out_idle_high: assert property (!serial_out_claim_o |-> serial_out_pin_o)
    else $error("data out not idle high");
  a_clock_rest_idle: assert property (!serial_out_claim_o && !$past(serial_out_claim_o) && !$past(wr_i) && !$past(wr_i, 2)
    |-> $stable(serial_clock_pin_o))
    else $error("clock moved outside a frame");
  a_txc_ack_clears: assert property (txc_irq_ack_i |=> !txc_irq_o)
    else $error("transmit done not cleared by service");
endmodule
bind umspi_top umspi_top_chk i_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .global_irq_en_i(global_irq_en_i), .txc_irq_ack_i(txc_irq_ack_i),
  .rxc_irq_o(rxc_irq_o), .txc_irq_o(txc_irq_o), .udre_irq_o(udre_irq_o), .serial_in_claim_o(serial_in_claim_o),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_claim_o(serial_out_claim_o),
  .serial_clock_pin_o(serial_clock_pin_o));

// [test/umspi_slave_model.sv]
// spi slave model: answers each frame with a reply byte, keeps the last byte seen
`timescale 1ns/1ps
module umspi_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  logic [7:0] sh;
  int         k;
  int         ns;
  function automatic logic pick(input int i);
    return lsb_i ? reply_i[i] : reply_i[7 - i];
  endfunction
  initial miso_o = 1'b1;
  // mode writes move the clock line, so the bench realigns us afterwards
  always @(posedge clr_i) begin
    k = 0;
    ns = 0;
    miso_o = pick(0);
  end
  always @(sclk_i) begin
    if (sclk_i ^ cpol_i ^ cpha_i) begin
      sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
      ns = (ns + 1) % 8;
      if (ns == 0) got_o = sh;
    end else if (cpha_i) begin
      miso_o = pick(k);
      k = (k + 1) % 8;
    end else begin
      k = (k + 1) % 8;
      miso_o = pick(k);
    end
  end
endmodule

// [test/tb_usart_master_spi_mode.sv]
// self-checking bench of the master spi serial port
`timescale 1ns/1ps
`include "umspi_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_usart_master_spi_mode;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        gie = 1'b1;
  logic        txc_ack = 1'b0;
  logic        clr = 1'b0;
  logic [7:0]  rdata, reply, got, b0, b1, r;
  logic [7:0]  mode = 8'h06;
  logic [7:0]  rr[3];
  logic        rxc_irq, txc_irq, udre_irq, miso, mosi, sclk;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic        rd_seen = 1'b0;
  int          n_mismatch = 0;
  int          checked = 0;
  int          m;
  int          i;
  always #50 mclk_i = ~mclk_i;
  umspi_top i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .global_irq_en_i(gie), .rxc_irq_ack_i(1'b0), .txc_irq_ack_i(txc_ack), .rxc_irq_o(rxc_irq),
    .txc_irq_o(txc_irq), .udre_irq_o(udre_irq), .serial_in_pin_i(miso), .serial_in_claim_o(),
    .serial_out_pin_o(mosi), .serial_out_claim_o(), .serial_clock_pin_o(sclk));
  umspi_slave_model i_slave (.sclk_i(sclk), .mosi_i(mosi), .cpol_i(mode[0]), .cpha_i(mode[1]), .lsb_i(mode[2]),
    .clr_i(clr), .reply_i(reply), .miso_o(miso), .got_o(got));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] ev, input logic [7:0] mk);
    exp_q.push_back({mk, ev});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge mclk_i) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK(rdata & e[15:8], e[7:0])
    end
    rd_seen = rd_i;
  end
  task automatic xfer(input logic [7:0] rv, input logic [7:0] tv);
    reply <= rv;
    @(posedge mclk_i);
    clr <= 1'b1;
    @(posedge mclk_i);
    clr <= 1'b0;
    wr(`UMSPI_ADDR_DATA, tv);
  endtask
  task automatic wait_txc();
    for (i = 0; i < 3000 && txc_irq !== 1'b1; i++) @(posedge mclk_i);
    if (txc_irq !== 1'b1) begin
      $display("ERROR %0t transfer never completed", $time);
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic ack_txc();
    txc_ack <= 1'b1;
    @(posedge mclk_i);
    txc_ack <= 1'b0;
    @(posedge mclk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(77));
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    rd(`UMSPI_ADDR_CTRL, 8'h06, 8'hFF);
    rd(`UMSPI_ADDR_STATUS, 8'h20, 8'hFF);
    rd(`UMSPI_ADDR_MODE, 8'h06, 8'hFF);
    rd(3'h7, 8'h00, 8'hFF);
    rd(`UMSPI_ADDR_DATA, 8'h00, 8'hFF);
    $display("test reset values done");
    for (m = 0; m < 4; m++) begin
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      r = 8'($urandom);
      mode = {`UMSPI_MODE_SPI, 3'h0, m[0] ^ m[1], m[0], m[1]};
      wr(`UMSPI_ADDR_MODE, mode);
      wr(`UMSPI_ADDR_BAUD_LO, 8'h03 + 8'($urandom % 4));
      wr(`UMSPI_ADDR_BAUD_HI, 8'h00);
      wr(`UMSPI_ADDR_CTRL, 8'h58);
      xfer(r, b0);
      wr(`UMSPI_ADDR_DATA, b1);
      rd(`UMSPI_ADDR_STATUS, 8'h00, 8'h20);
      wait_txc();
      `CHK(got, b1)
      rd(`UMSPI_ADDR_STATUS, 8'hE0, 8'hFF);
      rd(`UMSPI_ADDR_DATA, r, 8'hFF);
      rd(`UMSPI_ADDR_DATA, r, 8'hFF);
      rd(`UMSPI_ADDR_STATUS, 8'h60, 8'hFF);
      gie <= 1'b0;
      @(posedge mclk_i);
      `CHK(txc_irq, 1'b0)
      gie <= 1'b1;
      if (m[0]) ack_txc();
      else wr(`UMSPI_ADDR_STATUS, 8'h40);
      rd(`UMSPI_ADDR_STATUS, 8'h20, 8'hFF);
      $display("test spi mode %0d done", m);
    end
    for (m = 0; m < 3; m++) begin
      rr[m] = 8'($urandom);
      xfer(rr[m], 8'($urandom));
      wait_txc();
      ack_txc();
    end
    rd(`UMSPI_ADDR_DATA, rr[0], 8'hFF);
    rd(`UMSPI_ADDR_DATA, rr[1], 8'hFF);
    rd(`UMSPI_ADDR_STATUS, 8'h00, 8'h80);
    xfer(8'h5A, 8'h3C);
    wait_txc();
    ack_txc();
    wr(`UMSPI_ADDR_CTRL, 8'h48);
    rd(`UMSPI_ADDR_STATUS, 8'h00, 8'h80);
    rd(`UMSPI_ADDR_DATA, 8'h00, 8'hFF);
    $display("test overflow and flush done");
    b0 = 8'($urandom);
    wr(`UMSPI_ADDR_CTRL, 8'h50);
    xfer(8'hA5, b0);
    repeat (300) @(posedge mclk_i);
    rd(`UMSPI_ADDR_STATUS, 8'h00, 8'hC0);
    wr(`UMSPI_ADDR_CTRL, 8'h58);
    wr(`UMSPI_ADDR_CTRL, 8'h40);
    wait_txc();
    `CHK(got, b0)
    $display("test receiver alone and late disable done");
    complete_run();
  end
endmodule
